//--- hw/ptt_consts.vh
// Register offsets, field positions and reset values of the periodic tick unit.
`ifndef PTT_CONSTS_VH
`define PTT_CONSTS_VH

`define PTT_ADDR_W 8
`define PTT_OFF_CONTROL 8'h00
`define PTT_OFF_CONFIG 8'h04

`define PTT_CTL_RUN 1
`define PTT_CTL_IRQ_EN 2
`define PTT_CTL_ACK 3
`define PTT_CTL_TAP_LO 4
`define PTT_CTL_TAP_HI 6
`define PTT_CTL_FLAG 7

`define PTT_CFG_PRESCALE 0
`define PTT_CFG_KEEP_OSC 1

`define PTT_CHAIN_W 15
`define PTT_PRE_W 7
`define PTT_TAP_RESET 3'h0
`define PTT_TAP0_STAGE 4'hE
`define PTT_TAP1_STAGE 4'hC
`define PTT_TAP2_STAGE 4'hA
`define PTT_TAP3_STAGE 4'h6
`define PTT_TAP4_STAGE 4'h5
`define PTT_TAP5_STAGE 4'h4
`define PTT_TAP6_STAGE 4'h3
`define PTT_TAP7_STAGE 4'h2
`define PTT_CFG_RESET 2'h0

`define PTT_RESP_OKAY 2'h0
`define PTT_RESP_SLVERR 2'h2

`endif

//--- hw/ptt_timebase.v
// Periodic tick unit: divider chain, tick flag and its AXI4-Lite control registers.
//
// Overview of operation
// - Divider chain has 15 stages; eight stage outputs are selectable rollover taps.
// - Chain advances on rising edges of the oscillator source clock, not the bus clock.
// - Chain is held at all zeros whenever the run bit is clear.
// - Chain starts advancing once the run bit is set.
// - Tick flag sets each time the chain rolls over at the selected tap.
// - Interrupt request is raised while tick flag and interrupt enable are both set.
// - First tick comes after about half a period, later ticks at exact period.
// - Taps 0 to 7 divide by 32768, 8192, 2048, 128, 64, 32, 16, 8.
// - Extra prescale inserts divide-by-128 ahead, multiplying each divisor by 128.
// - Writing one to acknowledge clears the flag; writing zero does nothing.
// - Acknowledge bit is write-only and always reads zero.
// - Tick flag is read-only; a direct write to its position has no effect.
// - Chain and flag keep running during wait mode.
// - In stop mode the unit runs only if the oscillator is kept alive.
// - When active in stop mode, the tick request wakes the processor.
// - Control register cannot be reached while in wait or stop mode.
// - Interrupt enable is read/write, gates the request and clears at reset.
// - Run bit is read/write and clears at reset, leaving the counter at zero.
`include "ptt_consts.vh"

module ptt_timebase (
  // Clock and reset.
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address channel.
  input wire [`PTT_ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  // AXI4-Lite write data channel.
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // AXI4-Lite write response channel.
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address channel.
  input wire [`PTT_ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  // AXI4-Lite read data channel.
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Oscillator source clock from the clock generator, sampled as a level.
  input wire oscillator_source_clock,
  // System low-power state.
  input wire wait_mode,
  input wire stop_mode,
  // Requests to the processor.
  output reg tick_irq,
  output reg stop_wakeup
);

  // Control and configuration state.
  reg tick_run;
  reg tick_irq_enable;
  reg [2:0] tap_select;
  reg tick_flag;
  reg extra_prescale_select;
  reg oscillator_kept_in_stop;

  // Divider state.
  reg osc_prev;
  reg [`PTT_PRE_W-1:0] prescale;
  reg [`PTT_CHAIN_W-1:0] chain;

  // Bus holding state.
  reg aw_full;
  reg w_full;
  reg [`PTT_ADDR_W-1:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  // Stage index whose rising edge marks a rollover for each tap code.
  function [3:0] tap_bit;
    input [2:0] sel;
    begin
      case (sel)
        3'h0: tap_bit = `PTT_TAP0_STAGE;
        3'h1: tap_bit = `PTT_TAP1_STAGE;
        3'h2: tap_bit = `PTT_TAP2_STAGE;
        3'h3: tap_bit = `PTT_TAP3_STAGE;
        3'h4: tap_bit = `PTT_TAP4_STAGE;
        3'h5: tap_bit = `PTT_TAP5_STAGE;
        3'h6: tap_bit = `PTT_TAP6_STAGE;
        3'h7: tap_bit = `PTT_TAP7_STAGE;
        default: tap_bit = `PTT_TAP0_STAGE;
      endcase
    end
  endfunction

  // Register reached by a bus address.
  localparam SEL_NONE = 2'h0;
  localparam SEL_CTL = 2'h1;
  localparam SEL_CFG = 2'h2;

  // Address decode shared by the read and the write path.
  function [1:0] reg_sel;
    input [`PTT_ADDR_W-1:0] addr;
    begin
      case (addr)
        `PTT_OFF_CONTROL: reg_sel = SEL_CTL;
        `PTT_OFF_CONFIG: reg_sel = SEL_CFG;
        default: reg_sel = SEL_NONE;
      endcase
    end
  endfunction

  // The control register is closed while the system is in wait or stop mode.
  function [1:0] bus_resp;
    input [1:0] sel;
    input closed;
    begin
      case (sel)
        SEL_CTL: bus_resp = closed ? `PTT_RESP_SLVERR : `PTT_RESP_OKAY;
        SEL_CFG: bus_resp = `PTT_RESP_OKAY;
        default: bus_resp = `PTT_RESP_SLVERR;
      endcase
    end
  endfunction

  // Read value of a register; a closed or unmapped register reads zero.
  function [31:0] read_word;
    input [1:0] sel;
    input closed;
    input [7:0] ctl;
    input [1:0] cfg;
    begin
      case (sel)
        SEL_CTL: read_word = closed ? 32'h00000000 : {24'h000000, ctl};
        SEL_CFG: read_word = {30'h00000000, cfg};
        default: read_word = 32'h00000000;
      endcase
    end
  endfunction

  // Next-state values.
  reg [`PTT_PRE_W-1:0] next_prescale;
  reg [`PTT_CHAIN_W-1:0] next_chain;
  reg next_tick_run;
  reg next_tick_irq_enable;
  reg [2:0] next_tap_select;
  reg next_tick_flag;
  reg next_extra_prescale_select;
  reg next_oscillator_kept_in_stop;
  reg next_arready;
  reg next_rvalid;
  reg [31:0] next_rdata;
  reg [1:0] next_rresp;

  wire low_power = wait_mode | stop_mode;
  // The source clock is a sampled level, so it must stay high and low a bus clock each.
  wire osc_rise = oscillator_source_clock & ~osc_prev;
  // Stop mode freezes the chain unless the oscillator is kept alive there.
  wire unit_active = tick_run & (~stop_mode | oscillator_kept_in_stop);
  wire pre_wrap = (prescale == {`PTT_PRE_W{1'b1}});
  wire chain_step = unit_active & osc_rise & (~extra_prescale_select | pre_wrap);
  wire [`PTT_CHAIN_W-1:0] chain_inc = chain + 15'h0001;
  // The tap is applied at once, so a change while running may lose one tick.
  wire [3:0] tap_idx = tap_bit(tap_select);
  // A tap's stage rising gives the first tick after half a period, then every period.
  wire rollover = chain_step & chain_inc[tap_idx] & ~chain[tap_idx];

  // A write is carried out once both halves are held and no response is pending.
  wire do_write = aw_full & w_full & ~s_axi_bvalid;
  wire [1:0] wr_sel = reg_sel(aw_addr);
  wire [1:0] rd_sel = reg_sel(s_axi_araddr);
  wire wr_ctl = (wr_sel == SEL_CTL);
  wire wr_cfg = (wr_sel == SEL_CFG);
  // Control writes are refused in wait or stop mode so the bus cannot change the control word; config writes still land.
  wire ctl_write = do_write & wr_ctl & w_strb[0] & ~low_power;
  wire cfg_write = do_write & wr_cfg & w_strb[0];
  wire ack_write = ctl_write & w_data[`PTT_CTL_ACK];
  // The acknowledge position and bit 0 always read zero.
  wire [7:0] ctl_view = {tick_flag, tap_select, 1'b0, tick_irq_enable, tick_run, 1'b0};
  wire [1:0] cfg_view = {oscillator_kept_in_stop, extra_prescale_select};

  // Next state of the prescaler and the divider chain.
  always @* begin
    next_prescale = prescale;
    next_chain = chain;
    if (!tick_run) begin
      next_prescale = {`PTT_PRE_W{1'b0}};
      next_chain = {`PTT_CHAIN_W{1'b0}};
    end else begin
      if (unit_active & osc_rise & extra_prescale_select) begin
        next_prescale = prescale + 7'h01;
      end
      if (chain_step) begin
        next_chain = chain_inc;
      end
    end
  end

  // Divider chain and prescaler.
  always @(posedge aclk) begin
    if (!aresetn) begin
      osc_prev <= 1'b0;
      prescale <= {`PTT_PRE_W{1'b0}};
      chain <= {`PTT_CHAIN_W{1'b0}};
    end else begin
      osc_prev <= oscillator_source_clock;
      prescale <= next_prescale;
      chain <= next_chain;
    end
  end

  // Next state of the control and configuration registers and the tick flag.
  always @* begin
    next_tick_run = tick_run;
    next_tick_irq_enable = tick_irq_enable;
    next_tap_select = tap_select;
    next_extra_prescale_select = extra_prescale_select;
    next_oscillator_kept_in_stop = oscillator_kept_in_stop;
    next_tick_flag = tick_flag;
    if (ctl_write) begin
      next_tick_run = w_data[`PTT_CTL_RUN];
      next_tick_irq_enable = w_data[`PTT_CTL_IRQ_EN];
      next_tap_select = w_data[`PTT_CTL_TAP_HI:`PTT_CTL_TAP_LO];
    end
    if (cfg_write) begin
      next_extra_prescale_select = w_data[`PTT_CFG_PRESCALE];
      next_oscillator_kept_in_stop = w_data[`PTT_CFG_KEEP_OSC];
    end
    // A rollover in the same cycle as an acknowledge keeps the flag set.
    if (rollover) begin
      next_tick_flag = 1'b1;
    end else if (ack_write) begin
      next_tick_flag = 1'b0;
    end
  end

  // Control and configuration registers with the tick flag.
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_run <= 1'b0;
      tick_irq_enable <= 1'b0;
      tap_select <= `PTT_TAP_RESET;
      tick_flag <= 1'b0;
      extra_prescale_select <= 1'b0;
      oscillator_kept_in_stop <= 1'b0;
    end else begin
      tick_run <= next_tick_run;
      tick_irq_enable <= next_tick_irq_enable;
      tap_select <= next_tap_select;
      extra_prescale_select <= next_extra_prescale_select;
      oscillator_kept_in_stop <= next_oscillator_kept_in_stop;
      tick_flag <= next_tick_flag;
    end
  end

  // Requests to the processor.
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_irq <= 1'b0;
      stop_wakeup <= 1'b0;
    end else begin
      tick_irq <= tick_flag & tick_irq_enable;
      stop_wakeup <= tick_flag & tick_irq_enable & stop_mode & unit_active;
    end
  end

  // Write channels: address and data are taken in either order, one write at a time.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `PTT_RESP_OKAY;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= {`PTT_ADDR_W{1'b0}};
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= bus_resp(wr_sel, low_power);
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Next state of the read channel; the answer stands until it is taken.
  always @* begin
    next_arready = s_axi_arready;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid & s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = bus_resp(rd_sel, low_power);
      next_rdata = read_word(rd_sel, low_power, ctl_view, cfg_view);
    end else if (s_axi_rvalid & s_axi_rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
  end

  // Read channels: data is returned the cycle after the address is taken.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `PTT_RESP_OKAY;
    end else begin
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

endmodule

//--- tb/ptt_timebase_asserts.sv
// Assertions on the bus handshakes and requests of the periodic tick unit.
module ptt_timebase_asserts (
  // Clock, reset, power state and requests.
  input wire aclk, aresetn, wait_mode, stop_mode, tick_irq, stop_wakeup,
  // Bus channels.
  input wire s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire s_axi_rvalid, s_axi_rready,
  input wire [1:0] s_axi_bresp, s_axi_rresp,
  input wire [7:0] s_axi_araddr,
  input wire [31:0] s_axi_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing");
  chk_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  chk_wr_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write answer late");
  chk_wr_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  chk_ack_zero: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00
    |=> !s_axi_rdata[3]) else $error("acknowledge bit read as one");
  chk_lowpwr_block: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00
    && (wait_mode || stop_mode) |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("control reachable in low power");
  chk_wake_irq: assert property (stop_wakeup |-> tick_irq)
    else $error("wakeup without request");
  chk_wake_stop: assert property ($rose(stop_wakeup) |-> $past(stop_mode))
    else $error("wakeup outside stop");
endmodule

bind ptt_timebase ptt_timebase_asserts u_chk (.*);

//--- tb/test_periodic_timebase_tick.sv
// Self-checking bench for the periodic tick unit.
module test_periodic_timebase_tick;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, osc = 0, osc_on = 0, wait_mode = 0, stop_mode = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire tick_irq, stop_wakeup;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  logic [33:0] rq[$];
  logic [33:0] bq[$];
  int err_count = 0, checks_done = 0, rises = 0, r0, cyc = 0;

  ptt_timebase u_dut (.*, .s_axi_awprot(3'h0), .s_axi_arprot(3'h0), .s_axi_wstrb(4'hF),
    .oscillator_source_clock(osc));

  always #25 aclk = ~aclk;

  // Source clock of eight bus cycles a period, counted by its rising transitions.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (osc_on && cyc[1:0] == 2'h3) begin
      osc <= ~osc;
      rises <= rises + !osc;
    end
  end

  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) cmp({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready) cmp(s_axi_bresp, bq.pop_front());
  end

  task cmp(input logic [33:0] got, input logic [33:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task end_sim;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task tmo(input int n);
    if (n >= 6000) begin
      err_count++;
      $display("Error at %0t: timeout", $time);
      end_sim;
    end
  endtask

  task wr(input logic [7:0] a, d, input logic [1:0] r);
    int n;
    logic [31:0] w;
    w = $urandom();
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {w[31:8], d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      n++;
    end while (!s_axi_bvalid && n < 6000);
    s_axi_bready <= 0;
    tmo(n);
  endtask

  task rd(input logic [7:0] a, input logic [33:0] e);
    int n;
    rq.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    n = 0;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      n++;
    end while (!s_axi_rvalid && n < 6000);
    s_axi_rready <= 0;
    tmo(n);
  endtask

  // Waits for the tick request and checks how many source clocks it took.
  task wirq(input int exp);
    int n;
    for (n = 0; n < 6000 && tick_irq !== 1'h1; n++) @(posedge aclk);
    tmo(n);
    cmp(rises - r0, exp);
  endtask

  initial begin
    void'($urandom(32'h1FC74183));
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    rd(8'h00, 34'h0);
    wr(8'h00, 8'h7E, 2'h0);
    rd(8'h00, 34'h76);
    r0 = rises;
    osc_on <= 1;
    wirq(4);
    wr(8'h00, 8'hFE, 2'h0);
    wr(8'h00, 8'hF6, 2'h0);
    rd(8'h00, 34'h76);
    wirq(12);
    osc_on <= 0;
    wr(8'h00, 8'h74, 2'h0);
    rd(8'h00, 34'hF4);
    wr(8'h04, 8'h01, 2'h0);
    wr(8'h00, 8'h7E, 2'h0);
    r0 = rises;
    osc_on <= 1;
    repeat (2) @(posedge aclk);
    wirq(512);
    wait_mode <= 1;
    rd(8'h00, 34'h200000000);
    wr(8'h00, 8'h00, 2'h2);
    wr(8'h08, 8'h00, 2'h2);
    rd(8'h08, 34'h200000000);
    rd(8'h04, 34'h1);
    wait_mode <= 0;
    osc_on <= 0;
    rd(8'h00, 34'hF6);
    wr(8'h04, 8'h02, 2'h0);
    wr(8'h00, 8'h7C, 2'h0);
    wr(8'h00, 8'h76, 2'h0);
    r0 = rises;
    stop_mode <= 1;
    osc_on <= 1;
    wirq(4);
    cmp(stop_wakeup, 1);
    wr(8'h04, 8'h00, 2'h0);
    repeat (2) @(posedge aclk);
    cmp(stop_wakeup, 0);
    cmp(tick_irq, 1);
    end_sim;
  end
endmodule
